// ==== shared/crs_reset_map.vh ====
// Constants for the reset-state and early-configuration block.
`ifndef CRS_RESET_MAP_VH
`define CRS_RESET_MAP_VH

// ************************************************************
// Code segment and fetch address after reset
// ************************************************************
`define CRS_CS_SEL_RST      16'hF000
`define CRS_CS_BASE_RST     32'hFFFF0000
`define CRS_IP_RST          16'hFFF0
`define CRS_SEG_SHIFT       4
`define CRS_TOP_GAP_BYTES   16

// ************************************************************
// Main control register bit positions and reset values
// ************************************************************
`define CRS_CR_WAIT_MON     1
`define CRS_CR_TRAP_ALL     2
`define CRS_CR_TASK_SW      3
`define CRS_CR_FORCED_ONE   4
`define CRS_CR_FAULT_RPT    5
`define CRS_CR_NO_WB        29
`define CRS_CR_CACHE_DIS    30
`define CRS_CR_HW_RST       32'h60000010
`define CRS_CR_WARM_MASK    32'h60000000
`define CRS_CR_WARM_SET     32'h00000010

// ************************************************************
// Identification return register field positions
// ************************************************************
`define CRS_ID_STEP_LSB     0
`define CRS_ID_MODEL_LSB    4
`define CRS_ID_FAMILY_LSB   8
`define CRS_ID_TYPE_LSB     12
`define CRS_ID_EXT_MOD_LSB  16
`define CRS_ID_EXT_FAM_LSB  20

// ************************************************************
// FPU state values
// ************************************************************
`define CRS_FPU_TAG_RST     16'h5555
`define CRS_FPU_TAG_CLR     16'hFFFF
`define CRS_FPU_CW_RST      16'h0040
`define CRS_FPU_CW_CLR      16'h0300
`define CRS_FPU_TOP_CLR     3'h0

// ************************************************************
// Cache geometry
// ************************************************************
`define CRS_CACHE_LINES     64
`define CRS_CACHE_IDX_W     6

`endif

// ==== rtl/crs_reset_cfg.v ====
// Reset-state, FPU configuration and cache-enable logic of the processor core.
`timescale 1ns/10ps
`default_nettype none
`include "crs_reset_map.vh"

module crs_reset_cfg #(
   parameter [3:0] ID_STEPPING   = 4'h1, // Arbitrary identification value.
   parameter [3:0] ID_MODEL      = 4'h2, // Arbitrary identification value.
   parameter [3:0] ID_FAMILY     = 4'h3, // Arbitrary identification value.
   parameter [1:0] ID_TYPE       = 2'h1, // Arbitrary identification value.
   parameter [3:0] ID_EXT_MODEL  = 4'h4, // Arbitrary identification value.
   parameter [7:0] ID_EXT_FAMILY = 8'h05 // Arbitrary identification value.
) (
   // Clock and resets
   input  wire        ref_clk,
   input  wire        rst,
   input  wire        warm_restart_n,
   // Configuration straps
   input  wire        fpu_present,
   input  wire        emulator_present,
   // Control register write
   input  wire        cr_write,
   input  wire [31:0] cr_write_data,
   // Code segment and instruction pointer updates
   input  wire        cs_load,
   input  wire [15:0] cs_load_sel,
   input  wire        ip_load,
   input  wire [15:0] ip_load_value,
   // Floating-point instruction events
   input  wire        fp_instr,
   input  wire        fpu_sync_instr,
   input  wire        fpu_clear_instr,
   input  wire        fp_unmasked_exc,
   // Cache line fill and lookup
   input  wire        cache_fill,
   input  wire [5:0]  cache_fill_idx,
   input  wire [5:0]  cache_lookup_idx,
   // State outputs
   output reg  [31:0] id_return_register,
   output reg  [31:0] main_control_register,
   output reg  [15:0] cs_selector,
   output reg  [31:0] cs_base,
   output reg  [15:0] instruction_pointer,
   output reg  [31:0] fetch_addr,
   output reg         reset_base_active,
   output reg  [15:0] fpu_tag_word,
   output reg  [15:0] fpu_control_word,
   output reg  [2:0]  fpu_stack_top,
   output reg         cache_enable,
   output reg         cache_lookup_hit,
   // Exception outputs
   output reg         fp_execute,
   output reg         unit_absent_exception,
   output reg         fp_hang,
   output reg         fp_internal_error,
   output reg         fp_external_irq
);

   // ************************************************************
   // Helpers
   // ************************************************************
   function [31:0] crs_seg_base;
      input [15:0] sel;
      begin
         crs_seg_base = {12'h000, sel, 4'h0};
      end
   endfunction

   // ************************************************************
   // Warm-restart pin synchroniser
   // ************************************************************
   reg warm_meta;
   reg warm_sync_n;
   wire warm_active = ~warm_sync_n;

   always @(posedge ref_clk) begin
      if (rst) begin
         warm_meta   <= 1'b1;
         warm_sync_n <= 1'b1;
      end else begin
         warm_meta   <= warm_restart_n;
         warm_sync_n <= warm_meta;
      end
   end

   // ************************************************************
   // Identification value
   // ************************************************************
   always @(posedge ref_clk) begin
      // Both reset kinds leave the identification value, so boot code sees it at once.
      if (rst || warm_active) begin
         id_return_register <= {4'h0, ID_EXT_FAMILY, ID_EXT_MODEL, 2'b00, ID_TYPE,
                                ID_FAMILY, ID_MODEL, ID_STEPPING};
      end
   end

   // ************************************************************
   // Code segment, instruction pointer and fetch address
   // ************************************************************
   reg [15:0] next_cs_selector;
   reg [31:0] next_cs_base;
   reg [15:0] next_ip;
   reg        next_reset_base_active;

   always @* begin
      next_cs_selector       = cs_selector;
      next_cs_base           = cs_base;
      next_ip                = instruction_pointer;
      next_reset_base_active = reset_base_active;
      if (rst || warm_active) begin
         next_cs_selector       = `CRS_CS_SEL_RST;
         next_cs_base           = `CRS_CS_BASE_RST;
         next_ip                = `CRS_IP_RST;
         next_reset_base_active = 1'b1;
      end else begin
         // Boot code must not reload the selector while it still runs from the
         // reset base; the base would collapse below one megabyte.
         if (cs_load) begin
            next_cs_selector       = cs_load_sel;
            next_cs_base           = crs_seg_base(cs_load_sel);
            next_reset_base_active = 1'b0;
         end
         if (ip_load) begin
            next_ip = ip_load_value;
         end
      end
   end

   always @(posedge ref_clk) begin
      cs_selector         <= next_cs_selector;
      cs_base             <= next_cs_base;
      instruction_pointer <= next_ip;
      reset_base_active   <= next_reset_base_active;
      fetch_addr          <= next_cs_base + {16'h0000, next_ip};
   end

   // ************************************************************
   // Main control register
   // ************************************************************
   wire trap_all      = main_control_register[`CRS_CR_TRAP_ALL];
   wire wait_monitor  = main_control_register[`CRS_CR_WAIT_MON];
   wire task_switched = main_control_register[`CRS_CR_TASK_SW];
   wire fault_report  = main_control_register[`CRS_CR_FAULT_RPT];

   always @(posedge ref_clk) begin
      if (rst) begin
         // Trap, monitor and report flags clear; both cache flags set.
         main_control_register <= `CRS_CR_HW_RST;
      end else if (warm_active) begin
         main_control_register <= (main_control_register & `CRS_CR_WARM_MASK)
                                  | `CRS_CR_WARM_SET;
      end else if (cr_write) begin
         main_control_register <= cr_write_data | `CRS_CR_WARM_SET;
      end
   end

   // ************************************************************
   // Floating-point dispatch
   // ************************************************************
   wire fpu_usable = fpu_present & ~trap_all;
   wire fp_any     = fp_instr | fpu_clear_instr;
   wire fp_trap    = fp_any & ~fpu_usable & ~fp_hang;
   wire fp_stall   = fp_trap & trap_all & ~fpu_present & ~emulator_present;

   always @(posedge ref_clk) begin
      if (rst || warm_active) begin
         fp_execute            <= 1'b0;
         unit_absent_exception <= 1'b0;
         fp_internal_error     <= 1'b0;
         fp_external_irq       <= 1'b0;
      end else begin
         fp_execute            <= fp_any & fpu_usable & ~fp_hang;
         unit_absent_exception <= (fp_trap & ~fp_stall)
                                  | (fpu_sync_instr & wait_monitor & task_switched
                                     & ~fp_hang);
         fp_internal_error     <= fp_unmasked_exc & fault_report;
         fp_external_irq       <= fp_unmasked_exc & ~fault_report;
      end
   end

   // The hang is left only by a reset of either kind, as nothing can service it.
   always @(posedge ref_clk) begin
      if (rst || warm_active) begin
         fp_hang <= 1'b0;
      end else if (fp_stall) begin
         fp_hang <= 1'b1;
      end
   end

   // ************************************************************
   // FPU architectural state
   // ************************************************************
   always @(posedge ref_clk) begin
      if (rst) begin
         fpu_tag_word     <= `CRS_FPU_TAG_RST;
         fpu_control_word <= `CRS_FPU_CW_RST;
         fpu_stack_top    <= `CRS_FPU_TOP_CLR;
      end else if (!warm_active && fpu_clear_instr && fpu_usable && !fp_hang) begin
         fpu_tag_word     <= `CRS_FPU_TAG_CLR;
         fpu_control_word <= `CRS_FPU_CW_CLR;
         fpu_stack_top    <= `CRS_FPU_TOP_CLR;
      end
   end

   // ************************************************************
   // Internal cache valid bits
   // ************************************************************
   reg line_valid [0:`CRS_CACHE_LINES-1];
   integer i;

   always @(posedge ref_clk) begin
      if (rst) begin
         for (i = 0; i < `CRS_CACHE_LINES; i = i + 1) begin
            line_valid[i] <= 1'b0;
         end
      end else if (!warm_active && cache_fill && cache_enable) begin
         line_valid[cache_fill_idx] <= 1'b1;
      end
   end

   always @(posedge ref_clk) begin
      if (rst) begin
         cache_enable     <= 1'b0;
         cache_lookup_hit <= 1'b0;
      end else begin
         cache_enable     <= ~main_control_register[`CRS_CR_CACHE_DIS]
                             & ~main_control_register[`CRS_CR_NO_WB];
         cache_lookup_hit <= cache_enable & line_valid[cache_lookup_idx];
      end
   end

endmodule // crs_reset_cfg

`default_nettype wire

// ==== verification/crs_reset_cfg_properties.sv ====
// Concurrent checks on the reset-state, FPU configuration and cache-enable block.
`timescale 1ns/10ps
`default_nettype none
module crs_reset_props (
   // Clock, reset and straps
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic        fpu_present,
   input wire logic        emulator_present,
   // Requests
   input wire logic        cs_load,
   input wire logic [15:0] cs_load_sel,
   input wire logic        fp_instr,
   input wire logic        fpu_sync_instr,
   input wire logic        fpu_clear_instr,
   input wire logic        fp_unmasked_exc,
   // State and events
   input wire logic [31:0] main_control_register,
   input wire logic [31:0] cs_base,
   input wire logic [15:0] instruction_pointer,
   input wire logic [31:0] fetch_addr,
   input wire logic [15:0] cs_selector,
   input wire logic        reset_base_active,
   input wire logic [15:0] fpu_tag_word,
   input wire logic [15:0] fpu_control_word,
   input wire logic        cache_enable,
   input wire logic        fp_execute,
   input wire logic        unit_absent_exception,
   input wire logic        fp_hang,
   input wire logic        fp_internal_error,
   input wire logic        fp_external_irq
);
   wire [31:0] cr = main_control_register;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // ************************************************************
   // Properties
   // ************************************************************
   fetch_sum_a:
      assert property (fetch_addr == cs_base + {16'h0000, instruction_pointer})
      else $error("fetch address differs from base plus pointer");
   rst_state_a:
      assert property ($fell(rst) |-> cr == 32'h60000010 && cs_selector == 16'hF000
         && fetch_addr == 32'hFFFFFFF0 && reset_base_active)
      else $error("state after reset is wrong");
   cs_shift_a:
      assert property (cs_load |=> cs_base == {12'h000, $past(cs_load_sel), 4'h0}
         && !reset_base_active)
      else $error("selector load did not form a shifted base");
   fpu_route_a:
      assert property (fp_instr && fpu_present && !fp_hang |=>
         fp_execute == !$past(cr[2]) && unit_absent_exception == $past(cr[2]))
      else $error("floating-point routing wrong");
   hang_stick_a:
      assert property (fp_instr && cr[2] && !fpu_present && !emulator_present |=> fp_hang[*2])
      else $error("no hang without unit or emulator");
   nofpu_exc_a:
      assert property (fp_instr && !fpu_present && emulator_present && !fp_hang
         |=> unit_absent_exception)
      else $error("unit-absent exception missing without unit");
   sync_gate_a:
      assert property (fpu_sync_instr && !fp_instr && !fpu_clear_instr && !fp_hang
         |=> unit_absent_exception == ($past(cr[1]) && $past(cr[3])))
      else $error("sync instruction gating wrong");
   fault_path_a:
      assert property (fp_unmasked_exc |=> fp_internal_error == $past(cr[5])
         && fp_external_irq != $past(cr[5]))
      else $error("fault report path wrong");
   cache_on_a:
      assert property (cache_enable == !($past(cr[30]) || $past(cr[29])))
      else $error("cache enable does not follow flags");
   clear_state_a:
      assert property (fpu_clear_instr && fpu_present && !cr[2] && !fp_hang
         |=> fpu_tag_word == 16'hFFFF && fpu_control_word == 16'h0300)
      else $error("clear instruction left wrong state");
   forced_one_a:
      assert property (cr[4])
      else $error("control bit four not set");
   cover property (fp_hang);
   cover property (cache_enable);
   cover property (fp_instr && cr[2]);
endmodule // crs_reset_props
bind crs_reset_cfg crs_reset_props props_u (.ref_clk, .rst, .fpu_present, .emulator_present,
   .cs_load, .cs_load_sel, .fp_instr, .fpu_sync_instr, .fpu_clear_instr, .fp_unmasked_exc,
   .main_control_register, .cs_base, .instruction_pointer, .fetch_addr, .cs_selector,
   .reset_base_active, .fpu_tag_word, .fpu_control_word, .cache_enable, .fp_execute,
   .unit_absent_exception, .fp_hang, .fp_internal_error, .fp_external_irq);
`default_nettype wire

// ==== verification/crs_reset_cfg_tb.sv ====
// Self-checking testbench for the reset-state, FPU configuration and cache-enable block.
`timescale 1ns/10ps
`default_nettype none
module crs_reset_cfg_tb;
   logic        ref_clk = 1'b0, rst = 1'b1, warm_restart_n = 1'b1, fpu_present = 1'b1;
   logic        emulator_present = 1'b0, cr_write = 1'b0, cs_load = 1'b0, ip_load = 1'b0;
   logic        fp_instr = 1'b0, fpu_sync_instr = 1'b0, fpu_clear_instr = 1'b0;
   logic        fp_unmasked_exc = 1'b0, cache_fill = 1'b0;
   logic [31:0] cr_write_data = 32'h00000000;
   logic [15:0] cs_load_sel = 16'h0000, ip_load_value = 16'h0000;
   logic [5:0]  cache_fill_idx = 6'h05, cache_lookup_idx = 6'h05;
   wire  [31:0] id_return_register, main_control_register, cs_base, fetch_addr;
   wire  [15:0] cs_selector, instruction_pointer, fpu_tag_word, fpu_control_word;
   wire  [2:0]  fpu_stack_top;
   wire         reset_base_active, cache_enable, cache_lookup_hit, fp_execute;
   wire         unit_absent_exception, fp_hang, fp_internal_error, fp_external_irq;
   int          mismatches = 0, num_checks = 0, cycles = 0;
   crs_reset_cfg dut_u (.ref_clk, .rst, .warm_restart_n, .fpu_present, .emulator_present,
      .cr_write, .cr_write_data, .cs_load, .cs_load_sel, .ip_load, .ip_load_value, .fp_instr,
      .fpu_sync_instr, .fpu_clear_instr, .fp_unmasked_exc, .cache_fill, .cache_fill_idx,
      .cache_lookup_idx, .id_return_register, .main_control_register, .cs_selector, .cs_base,
      .instruction_pointer, .fetch_addr, .reset_base_active, .fpu_tag_word, .fpu_control_word,
      .fpu_stack_top, .cache_enable, .cache_lookup_hit, .fp_execute, .unit_absent_exception,
      .fp_hang, .fp_internal_error, .fp_external_irq);
   initial forever #2.5 ref_clk = ~ref_clk;
   // The run needs about 55 cycles; the ceiling leaves wide margin.
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         end_of_test;
      end
   end
   // ************************************************************
   // Helpers
   // ************************************************************
   task automatic step(input int n = 1);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wcr(input logic [31:0] d);
      cr_write = 1'b1;
      cr_write_data = d;
      step();
      cr_write = 1'b0;
   endtask
   task automatic pulse_fp;
      fp_instr = 1'b1;
      step();
      fp_instr = 1'b0;
   endtask
   task automatic end_of_test;
      if (mismatches == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_reset;
      chk(main_control_register, 32'h60000010);
      chk(id_return_register, 32'h00541321);
      chk(cs_selector, 16'hF000);
      chk(cs_base, 32'hFFFF0000);
      chk(instruction_pointer, 16'hFFF0);
      chk(reset_base_active, 1'b1);
      chk(fetch_addr, 32'hFFFFFFF0);
      chk(cache_enable, 1'b0);
      chk(cache_lookup_hit, 1'b0);
   endtask
   task automatic t_cs;
      cs_load = 1'b1;
      cs_load_sel = 16'h1234;
      ip_load = 1'b1;
      ip_load_value = 16'h0100;
      step();
      cs_load = 1'b0;
      ip_load = 1'b0;
      chk(cs_base, 32'h00012340);
      chk(fetch_addr, 32'h00012440);
      chk(reset_base_active, 1'b0);
   endtask
   task automatic t_cache;
      cache_fill = 1'b1;
      step();
      cache_fill = 1'b0;
      step();
      chk(cache_lookup_hit, 1'b0);
      wcr(32'h00000000);
      chk(main_control_register, 32'h00000010);
      chk(cache_enable, 1'b0);
      step();
      chk(cache_enable, 1'b1);
      cache_fill = 1'b1;
      step();
      cache_fill = 1'b0;
      step();
      chk(cache_lookup_hit, 1'b1);
      cache_lookup_idx = 6'h06;
      step();
      chk(cache_lookup_hit, 1'b0);
   endtask
   task automatic t_fpu;
      pulse_fp();
      chk({fp_execute, unit_absent_exception}, 2'h2);
      fpu_clear_instr = 1'b1;
      step();
      fpu_clear_instr = 1'b0;
      chk({fpu_tag_word, fpu_control_word}, 32'hFFFF0300);
      chk(fpu_stack_top, 3'h0);
      wcr(32'h00000024);
      pulse_fp();
      chk({fp_execute, unit_absent_exception}, 2'h1);
      fp_unmasked_exc = 1'b1;
      step();
      fp_unmasked_exc = 1'b0;
      chk({fp_internal_error, fp_external_irq}, 2'h2);
      for (int i = 0; i < 2; i++) begin
         wcr(i ? 32'h00000008 : 32'h0000000A);
         fpu_sync_instr = 1'b1;
         step();
         fpu_sync_instr = 1'b0;
         chk(unit_absent_exception, i ? 1'b0 : 1'b1);
      end
      fp_unmasked_exc = 1'b1;
      step();
      fp_unmasked_exc = 1'b0;
      chk({fp_internal_error, fp_external_irq}, 2'h1);
   endtask
   task automatic t_nofpu;
      fpu_present = 1'b0;
      emulator_present = 1'b1;
      wcr(32'h00000000);
      pulse_fp();
      chk(unit_absent_exception, 1'b1);
      emulator_present = 1'b0;
      wcr(32'h00000026);
      pulse_fp();
      step(2);
      chk(fp_hang, 1'b1);
   endtask
   task automatic t_warm;
      warm_restart_n = 1'b0;
      step(4);
      warm_restart_n = 1'b1;
      step(4);
      chk(id_return_register, 32'h00541321);
      chk(main_control_register, 32'h00000010);
      chk(fetch_addr, 32'hFFFFFFF0);
      chk({fpu_tag_word, fpu_control_word}, 32'hFFFF0300);
      chk(fp_hang, 1'b0);
      cache_lookup_idx = 6'h05;
      step();
      chk(cache_lookup_hit, 1'b1);
   endtask
   initial begin
      step(20);
      rst = 1'b0;
      step();
      t_reset();
      t_cs();
      t_cache();
      t_fpu();
      t_nofpu();
      t_warm();
      end_of_test();
   end
endmodule // crs_reset_cfg_tb
`default_nettype wire
